// >>> bench/clv_ctrl_model.sv
// Behavioural system controller that drives the register port.
module clv_ctrl_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
  end
  // A quarter-dB target is floored to half-dB steps before it is coded.
  function automatic logic [7:0] code_of(input int q);
    return 8'((q >>> 1) + 210);
  endfunction : code_of
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge ref_clk);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    reg_addr = a;
    @(negedge ref_clk);
    d = reg_rdata;
  endtask : rd
endmodule : clv_ctrl_model

// >>> bench/clv_level_regs_checker.sv
// Assertions on the ports of the channel level and silence register bank.
module clv_level_regs_checker
  import clv_pkg::*;
#(
  parameter int CHANNELS = 8
) (
  input wire logic                     ref_clk,
  input wire logic                     rst,
  input wire logic [7:0]               reg_addr,
  input wire logic [7:0]               reg_wdata,
  input wire logic                     reg_wr,
  input wire logic [7:0]               reg_rdata,
  input wire logic                     silence_pin,
  input wire logic [CHANNELS-1:0][9:0] level_q,
  input wire logic [CHANNELS-1:0]      silenced
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [7:0] cfg_reg;
  logic [1:0] pol_reg;
  logic       pin_act;
  // Shadows of the pin and policy settings, updated on the same edge as the bank.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_reg <= {2'b00, CFG_PIN_RESET};
      pol_reg <= CFG_ZC_RESET[1:0];
    end else if (reg_wr && reg_addr == ADDR_CFG_PIN) begin
      cfg_reg <= reg_wdata;
    end else if (reg_wr && reg_addr == ADDR_CFG_ZC) begin
      pol_reg <= reg_wdata[1:0];
    end
  end
  assign pin_act = cfg_reg[5] && (silence_pin == cfg_reg[4]);
  sequence s_wr_bank;
    reg_wr && reg_addr inside {[8'h01:8'h0a]};
  endsequence
  sequence s_idle_hold;
    !reg_wr && $stable(reg_addr);
  endsequence
  a_reset_outputs: assert property ($fell(rst) |-> level_q == '0 && silenced == '0)
    else $error("outputs not at reset state");
  a_unmapped_zero: assert property (!(reg_addr inside {[8'h01:8'h0c]}) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_write_readback: assert property (s_wr_bank ##1 s_idle_hold |=> reg_rdata == $past(reg_wdata, 2))
    else $error("written value not read back");
  a_cfg_reserved: assert property (reg_addr == ADDR_CFG_PIN |=> reg_rdata[7:6] == 2'h0)
    else $error("reserved config bits not zero");
  a_immediate_top: assert property (reg_wr && reg_addr == ADDR_LEVEL_FIRST && reg_wdata == 8'hfe
    && pol_reg == ZC_IMMEDIATE ##1 !reg_wr |=> ##1 level_q[0] == 10'd88)
    else $error("immediate level not applied");
  a_pin_silence: assert property (pin_act [*4] |-> silenced == '1)
    else $error("active pin did not silence");
  for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
    a_span_limit: assert property ($signed(level_q[i]) <= 88 && $signed(level_q[i]) >= -384)
      else $error("level outside span");
    if (i % 2 == 0) begin : g_low
      a_silence_bit: assert property (reg_wr && reg_addr == ADDR_SILENCE && reg_wdata[i]
        ##1 !reg_wr |=> silenced[i])
        else $error("silence bit did not silence");
    end
  end
endmodule : clv_level_regs_checker

bind clv_level_regs clv_level_regs_checker #(.CHANNELS(CHANNELS)) u_chk (.ref_clk(ref_clk),
  .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rdata(reg_rdata), .silence_pin(silence_pin), .level_q(level_q), .silenced(silenced));

// >>> bench/clv_level_regs_tb.sv
// Self-checking testbench for the channel level and silence register bank.
module clv_level_regs_tb;
  import clv_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic             ref_clk, rst, reg_wr, silence_pin;
  logic [7:0]       reg_addr, reg_wdata, reg_rdata, zero_cross, silenced;
  logic [7:0][9:0]  level_q;
  int               err_total, cmp_count;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %0t got %h exp %h", $time, (g), (e)); end end
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  clv_level_regs #(.CHANNELS(8), .CYCLES_PER_MS_P(2)) dut (.ref_clk(ref_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .silence_pin(silence_pin), .zero_cross(zero_cross), .level_q(level_q), .silenced(silenced));
  clv_ctrl_model ctl (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr));
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  function automatic logic [9:0] lvl(input int c, input int f);
    int v;
    v = 2 * c - 420 + f;
    v = v > 88 ? 88 : v < -384 ? -384 : v;
    return 10'(v);
  endfunction : lvl
  task automatic t_reset();
    logic [7:0] d;
    for (int a = 1; a <= 13; a++) begin
      ctl.rd(8'(a), d);
      `CHK(d, a <= 8 ? 8'hd2 : a == 11 ? 8'h20 : a == 12 ? 8'h0d : 8'h00)
    end
    `CHK(silenced, 8'h00)
  endtask : t_reset
  task automatic t_levels();
    logic [7:0] c [5] = '{8'hfe, 8'h12, 8'hff, 8'h00, 8'hd3};
    ctl.wr(ADDR_CFG_ZC, 8'h0c);
    for (int i = 0; i < 5; i++) begin
      ctl.wr(ADDR_LEVEL_FIRST, c[i]);
      cyc(2);
      `CHK(level_q[0], lvl(c[i], 0))
    end
    ctl.wr(ADDR_LEVEL_FIRST, ctl.code_of(-1));
    ctl.wr(ADDR_FINE, 8'h01);
    cyc(2);
    `CHK(level_q[0], 10'h3ff)
  endtask : t_levels
  task automatic t_link();
    ctl.wr(8'h02, 8'he0);
    cyc(2);
    `CHK(level_q[1], lvl(8'he0, 0))
    ctl.wr(ADDR_SILENCE, 8'h55);
    for (int p = 0; p < 4; p++) begin
      ctl.wr(ADDR_CFG_PIN, 8'h20 | 8'(1 << p));
      cyc(2);
      `CHK(silenced, 8'h55 | 8'(2 << 2 * p))
    end
    ctl.wr(ADDR_CFG_PIN, 8'h21);
    cyc(2);
    `CHK(level_q[1], 10'h3ff)
    ctl.wr(ADDR_SILENCE, 8'h00);
    cyc(2);
    `CHK(silenced, 8'h00)
  endtask : t_link
  task automatic t_pin();
    logic [7:0] cfg [4] = '{8'h20, 8'h30, 8'h30, 8'h10};
    logic       pin [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    logic [7:0] ex [4]  = '{8'hff, 8'h00, 8'hff, 8'h00};
    for (int i = 0; i < 4; i++) begin
      ctl.wr(ADDR_CFG_PIN, cfg[i]);
      silence_pin = pin[i];
      cyc(4);
      `CHK(silenced, ex[i])
    end
  endtask : t_pin
  task automatic t_zc();
    ctl.wr(ADDR_CFG_ZC, 8'h05);
    ctl.wr(8'h03, 8'he0);
    cyc(4);
    `CHK(level_q[2], 10'h000)
    cyc(24);
    `CHK(level_q[2], lvl(8'he0, 0))
    ctl.wr(8'h03, 8'hf0);
    zero_cross = 8'h04;
    cyc(2);
    zero_cross = 8'h00;
    cyc(4);
    `CHK(level_q[2], lvl(8'hf0, 0))
    ctl.wr(8'h03, 8'hd4);
    ctl.wr(8'h03, 8'he0);
    cyc(3);
    `CHK(level_q[2], lvl(8'hf0, 0))
    cyc(24);
    `CHK(level_q[2], lvl(8'he0, 0))
    ctl.wr(ADDR_CFG_ZC, 8'h06);
    ctl.wr(8'h03, 8'hd4);
    ctl.wr(8'h03, 8'hfe);
    cyc(3);
    `CHK(level_q[2], lvl(8'hd4, 0))
  endtask : t_zc
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    give_verdict();
  end
  initial begin
    err_total = 0;
    cmp_count = 0;
    rst = 1'b1;
    silence_pin = 1'b1;
    zero_cross = 8'h00;
    cyc(12);
    rst = 1'b0;
    t_reset();
    $display("t_reset done");
    t_levels();
    $display("t_levels done");
    t_link();
    $display("t_link done");
    t_pin();
    $display("t_pin done");
    t_zc();
    $display("t_zc done");
    give_verdict();
  end
endmodule : clv_level_regs_tb

// >>> design/clv_level_regs.sv
// Register bank for per-channel level and silence with pin control and pair linking.
//
// Operation
// R1: Eight level registers, reset to 0 dB.
// R2: Code equals twice dB plus 210.
// R3: Controller rounds quarter-dB target down first.
// R4: Out-of-span codes accepted, level clamped.
// R5: Level changes follow zero-cross policy and time-out.
// R6: Fine-step bit adds quarter dB, resets zero.
// R7: Silence bit silences its channel while set.
// R8: Config bit 5 enables silence pin.
// R9: Config bit 4 selects pin active level.
// R10: Link bit makes pair follow lower channel.
// R11: Link bits 3..0 pair channels 7/8..1/2.
// R12: Policy field chooses immediate, discard or apply-old.
// R13: Time-out field selects 5 to 50 ms.
// R14: Quarter-dB level is twice code minus 420.
// R15: Silenced by own bit or active pin.
module clv_level_regs
  import clv_pkg::*;
#(
  parameter int CHANNELS       = 8,
  parameter int CYCLES_PER_MS_P = CYCLES_PER_MS
) (
  // Clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  // Register port from the serial control port
  input  wire logic [7:0]                reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  output logic      [7:0]                reg_rdata,
  // Pins
  input  wire logic                      silence_pin,
  input  wire logic [CHANNELS-1:0]       zero_cross,
  // Effective state
  output logic      [CHANNELS-1:0][9:0]  level_q,
  output logic      [CHANNELS-1:0]       silenced
);

  typedef struct packed {
    logic [CHANNELS-1:0][7:0] level;
    logic [CHANNELS-1:0]      fine;
    logic [CHANNELS-1:0]      sil;
    logic [5:0]               cfg_pin;
    logic [4:0]               cfg_zc;
    logic [1:0]               pin_sync;
    logic [CHANNELS-1:0]      zc_s1;
    logic [CHANNELS-1:0]      zc_s2;
    logic [7:0]               rdata;
    logic [CHANNELS-1:0][9:0] lvl_out;
    logic [CHANNELS-1:0]      sil_out;
  } clv_state_t;

  clv_state_t cur_reg;
  clv_state_t cur_next;

  logic [CHANNELS-1:0][8:0] desired;
  logic [CHANNELS-1:0][8:0] applied;
  logic [CHANNELS-1:0]      eff_sil;
  logic [TMO_W-1:0]         timeout_cycles;

  // Quarter-dB level from a code and fine-step bit, clamped to the analog span.
  function automatic logic [9:0] quarter_level(input logic [8:0] cf);
    logic signed [10:0] v;
    v = $signed({2'b00, cf[8:1], 1'b0}) + $signed({10'h000, cf[0]})
        - 11'(LEVEL_OFFSET_Q); // R14
    if (v > LEVEL_MAX_Q) begin
      v = LEVEL_MAX_Q; // R4
    end else if (v < LEVEL_MIN_Q) begin
      v = LEVEL_MIN_Q; // R4
    end
    quarter_level = v[9:0];
  endfunction : quarter_level

  assign timeout_cycles = TMO_W'(timeout_ms(cur_reg.cfg_zc[ZC_TIMEOUT_LSB +: 3])
                                 * CYCLES_PER_MS_P); // R13

  // Odd-numbered channel of a linked pair follows its lower partner.
  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_ch
      localparam int SRC_LINKED = ch - (ch % 2);
      logic linked;
      assign linked = (ch % 2 == 1)
                      && cur_reg.cfg_pin[LINK_PAIR_ONE_TWO_BIT + ch / 2]; // R10 R11
      assign desired[ch] = linked
          ? {cur_reg.level[SRC_LINKED], cur_reg.fine[SRC_LINKED]}
          : {cur_reg.level[ch], cur_reg.fine[ch]}; // R10
      assign eff_sil[ch] = linked ? cur_reg.sil[SRC_LINKED] : cur_reg.sil[ch]; // R10

      clv_zc_sched u_sched (
        .ref_clk           (ref_clk),
        .rst               (rst),
        .zero_cross_policy (cur_reg.cfg_zc[ZC_POLICY_LSB +: 2]),
        .timeout_cycles    (timeout_cycles),
        .desired           (desired[ch]),
        .zero_cross        (cur_reg.zc_s2[ch]),
        .applied           (applied[ch])
      ); // R5
    end
  endgenerate

  always_comb begin
    logic pin_active;
    pin_active        = 1'b0;
    cur_next          = cur_reg;
    cur_next.pin_sync = {cur_reg.pin_sync[0], silence_pin};
    cur_next.zc_s1    = zero_cross;
    cur_next.zc_s2    = cur_reg.zc_s1;

    if (reg_wr) begin
      if (reg_addr >= ADDR_LEVEL_FIRST && reg_addr <= ADDR_LEVEL_LAST) begin
        cur_next.level[3'(reg_addr - ADDR_LEVEL_FIRST)] = reg_wdata; // R1 R2
      end else if (reg_addr == ADDR_FINE) begin
        cur_next.fine = reg_wdata; // R6
      end else if (reg_addr == ADDR_SILENCE) begin
        cur_next.sil = reg_wdata; // R7
      end else if (reg_addr == ADDR_CFG_PIN) begin
        cur_next.cfg_pin = reg_wdata[5:0]; // R8 R9 R11
      end else if (reg_addr == ADDR_CFG_ZC) begin
        cur_next.cfg_zc = reg_wdata[4:0]; // R12 R13
      end
    end

    // Read data follow the address one cycle later; unmapped addresses read zero.
    if (reg_addr >= ADDR_LEVEL_FIRST && reg_addr <= ADDR_LEVEL_LAST) begin
      cur_next.rdata = cur_reg.level[3'(reg_addr - ADDR_LEVEL_FIRST)];
    end else if (reg_addr == ADDR_FINE) begin
      cur_next.rdata = cur_reg.fine;
    end else if (reg_addr == ADDR_SILENCE) begin
      cur_next.rdata = cur_reg.sil;
    end else if (reg_addr == ADDR_CFG_PIN) begin
      cur_next.rdata = {2'b00, cur_reg.cfg_pin};
    end else if (reg_addr == ADDR_CFG_ZC) begin
      cur_next.rdata = {3'b000, cur_reg.cfg_zc};
    end else begin
      cur_next.rdata = 8'h00;
    end

    pin_active = cur_reg.cfg_pin[SILENCE_PIN_ENABLE_BIT]
                 && (cur_reg.pin_sync[1] == cur_reg.cfg_pin[SILENCE_PIN_LEVEL_BIT]); // R8 R9
    for (int i = 0; i < CHANNELS; i++) begin
      cur_next.lvl_out[i] = quarter_level(applied[i]); // R6 R14
      cur_next.sil_out[i] = eff_sil[i] | pin_active; // R7 R15
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_reg          <= '0;
      cur_reg.level    <= {CHANNELS{LEVEL_RESET}}; // R1
      cur_reg.fine     <= FINE_RESET[CHANNELS-1:0]; // R6
      cur_reg.sil      <= SILENCE_RESET[CHANNELS-1:0]; // R7
      cur_reg.cfg_pin  <= CFG_PIN_RESET; // R8 R9 R10
      cur_reg.cfg_zc   <= CFG_ZC_RESET; // R12 R13
      cur_reg.pin_sync <= 2'b11;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign reg_rdata = cur_reg.rdata;
  assign level_q   = cur_reg.lvl_out;
  assign silenced  = cur_reg.sil_out;

endmodule : clv_level_regs

// >>> design/clv_pkg.sv
// Package of constants shared by the channel level and silence register bank.
package clv_pkg;

  // Register map and reset values.
  localparam logic [7:0] ADDR_LEVEL_FIRST = 8'h01;
  localparam logic [7:0] ADDR_LEVEL_LAST  = 8'h08;
  localparam logic [7:0] ADDR_FINE        = 8'h09;
  localparam logic [7:0] ADDR_SILENCE     = 8'h0a;
  localparam logic [7:0] ADDR_CFG_PIN     = 8'h0b;
  localparam logic [7:0] ADDR_CFG_ZC      = 8'h0c;
  localparam logic [7:0] LEVEL_RESET      = 8'hd2;
  localparam logic [7:0] FINE_RESET       = 8'h00;
  localparam logic [7:0] SILENCE_RESET    = 8'h00;
  localparam logic [5:0] CFG_PIN_RESET    = 6'h20;
  localparam logic [4:0] CFG_ZC_RESET     = 5'h0d;

  // Field positions in the pin and pairing configuration register.
  localparam int SILENCE_PIN_ENABLE_BIT = 5;
  localparam int SILENCE_PIN_LEVEL_BIT  = 4;
  localparam int LINK_PAIR_ONE_TWO_BIT  = 0;

  // Field positions in the zero-cross configuration register.
  localparam int ZC_POLICY_LSB  = 0;
  localparam int ZC_TIMEOUT_LSB = 2;

  // Zero-cross policies.
  localparam logic [1:0] ZC_IMMEDIATE   = 2'h0;
  localparam logic [1:0] ZC_DISCARD_OLD = 2'h1;
  localparam logic [1:0] ZC_APPLY_OLD   = 2'h2;

  // Level span in quarter-dB units: +22 dB and -96 dB.
  localparam int                LEVEL_OFFSET_Q = 420;
  localparam logic signed [10:0] LEVEL_MAX_Q    = 11'sd88;
  localparam logic signed [10:0] LEVEL_MIN_Q    = -11'sd384;

  // Timing.
  localparam int CLK_PERIOD_NS = 4;
  localparam int NS_PER_MS     = 1000000;
  localparam int CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
  localparam int TMO_W         = 24;

  // Time-out period in milliseconds for each time-out code.
  function automatic logic [7:0] timeout_ms(input logic [2:0] code);
    unique case (code)
      3'h0: timeout_ms = 8'd5;
      3'h1: timeout_ms = 8'd10;
      3'h2: timeout_ms = 8'd15;
      3'h3: timeout_ms = 8'd18;
      3'h4: timeout_ms = 8'd20;
      3'h5: timeout_ms = 8'd30;
      3'h6: timeout_ms = 8'd40;
      3'h7: timeout_ms = 8'd50;
    endcase
  endfunction : timeout_ms

endpackage : clv_pkg

// >>> design/clv_zc_sched.sv
// Per-channel scheduler that applies level changes under the zero-cross policy.
module clv_zc_sched
  import clv_pkg::*;
(
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst,
  // Settings
  input  wire logic [1:0]       zero_cross_policy,
  input  wire logic [TMO_W-1:0] timeout_cycles,
  input  wire logic [8:0]       desired,
  input  wire logic             zero_cross,
  // Result
  output logic      [8:0]       applied
);

  typedef struct packed {
    logic [8:0]       applied;
    logic [8:0]       pending;
    logic             pend;
    logic [8:0]       last;
    logic [TMO_W-1:0] cnt;
  } clv_sched_t;

  localparam clv_sched_t SCHED_RESET = '{
    applied: {LEVEL_RESET, 1'b0}, pending: {LEVEL_RESET, 1'b0}, pend: 1'b0,
    last: {LEVEL_RESET, 1'b0}, cnt: '0};

  clv_sched_t cur_reg;
  clv_sched_t cur_next;

  always_comb begin
    cur_next      = cur_reg;
    cur_next.last = desired;
    if (cur_reg.pend) begin
      if (zero_cross || cur_reg.cnt == '0) begin
        cur_next.applied = cur_reg.pending; // R5
        cur_next.pend    = 1'b0;
      end else begin
        cur_next.cnt = cur_reg.cnt - 1'b1;
      end
    end
    if (desired != cur_reg.last) begin
      if (zero_cross_policy == ZC_IMMEDIATE) begin
        cur_next.applied = desired; // R12
        cur_next.pend    = 1'b0;
      end else begin
        // A newer change replaces the pending one; the apply-old policy lands it first.
        if (zero_cross_policy == ZC_APPLY_OLD && cur_reg.pend) begin
          cur_next.applied = cur_reg.pending; // R12
        end
        cur_next.pending = desired;
        cur_next.pend    = 1'b1;
        cur_next.cnt     = timeout_cycles; // R13
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_reg <= SCHED_RESET;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign applied = cur_reg.applied;

endmodule : clv_zc_sched
